// *** design/port_ingress_mac_policy_params.svh ***
// Offsets, field positions, reset values and timing counts of the ingress MAC policy block.
// Assumes a byte-wide register port with a 12-bit byte address.
`ifndef PORT_INGRESS_MAC_POLICY_PARAMS_SVH
`define PORT_INGRESS_MAC_POLICY_PARAMS_SVH
`define OFS_MAC_STORM     12'h0400
`define OFS_MAC_BACKPR    12'h0401
`define OFS_RATE_CTRL     12'h0403
`define OFS_PRIO_LIM_BASE 12'h0410
`define OFS_PRIO_LIM_LAST 12'h0417
`define OFS_LIM_STATUS    12'h0420
`define BIT_STORM_EN      1
`define BIT_BACKPR_EN     3
`define BIT_PASS_ALL      0
`define BIT_PORT_BASED    6
`define BIT_PPS_MODE      5
`define BIT_LIM_FC_EN     4
`define BIT_CNT_IFG       1
`define BIT_CNT_PRE       0
`define RST_CTRL          8'h00
`define IFG_BYTES         24'h00_000C
`define PRE_BYTES         24'h00_0008
`define CLK_MHZ           25
`define WINDOW_US         1000
`define WINDOW_CYC        (`WINDOW_US * `CLK_MHZ)
`define BITS_PER_CODE     24'h00_03E8
`define PKTS_PER_CODE     24'h00_0002
`define STORM_LIMIT       24'h00_0040
`endif

// *** design/port_ingress_mac_policy_pkg.sv ***
// Types shared by the ingress MAC policy block.
// Assumes the constants header is compiled alongside.
package port_ingress_mac_policy_pkg;
  typedef enum logic [1:0] {
    CLS_ALL      = 2'b00,
    CLS_BMC_FLD  = 2'b01,
    CLS_BMC      = 2'b10,
    CLS_BC       = 2'b11
  } lim_class_t;

  typedef struct packed {
    logic             storm_en;
    logic             backpr_en;
    logic             pass_all;
    logic [6:0]       rate_ctrl;
    logic [7:0][6:0]  pend;
    logic [7:0][6:0]  act;
    logic [7:0][23:0] usage;
    logic [7:0]       hit;
    logic [23:0]      bc_cnt;
    logic [14:0]      win_cnt;
    logic [7:0]       rdata;
    logic             dec_valid;
    logic             dec_forward;
    logic             dec_mirror_only;
    logic             dec_drop;
    logic             pause_req;
    logic             backpr_req;
  } state_t;
endpackage : port_ingress_mac_policy_pkg

// *** design/port_ingress_mac_policy.sv ***
// Per-port ingress MAC policy: bad-frame handling, storm protection and ingress rate limiting.
// Assumes one frame summary pulse per received frame, synchronous to core_clk.
//
// Overview of operation
// - Storm enable bit set drops broadcasts over the window limit; clear means none.
// - Back pressure acts only in half duplex; full duplex uses pause requests.
// - Pass-all clear drops frames with CRC error, oversize or undersize.
// - Pass-all set sends bad frames only to mirroring, never normal forwarding.
// - Flow control frame filtering follows the switch-level control, not pass-all.
// - Port-based bit one uses one port limit; zero uses per-priority limits.
// - Packet-mode bit one counts frames; zero counts bits.
// - Limiter flow control bit set asserts flow control when the limit is exceeded.
// - Limiter flow control needs the port's own flow control enabled too.
// - Class field chooses counted frames: all, bc/mc/flood, bc/mc, bc only.
// - Gap bit adds twelve bytes per frame to the byte count.
// - Preamble bit adds eight bytes per frame to the byte count.
// - Preamble bit is ignored in packet-counting mode.
// - Priority limits stay pending until the priority seven limit is written.
`include "port_ingress_mac_policy_params.svh"

module port_ingress_mac_policy #(
  parameter int unsigned WINDOW_CYCLES = `WINDOW_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        full_duplex,
  input  wire logic        port_fc_en,
  input  wire logic        fc_filter_en,
  input  wire logic        frm_valid,
  input  wire logic [13:0] frm_len,
  input  wire logic [2:0]  frm_prio,
  input  wire logic        frm_crc_err,
  input  wire logic        frm_too_long,
  input  wire logic        frm_too_short,
  input  wire logic        frm_bcast,
  input  wire logic        frm_mcast,
  input  wire logic        frm_flood,
  input  wire logic        frm_is_fc,
  output logic             dec_valid,
  output logic             dec_forward,
  output logic             dec_mirror_only,
  output logic             dec_drop,
  output logic             pause_req,
  output logic             backpressure_req
);
  import port_ingress_mac_policy_pkg::*;

  localparam logic [14:0] WIN_LAST = 15'(WINDOW_CYCLES - 1);

  state_t s_r;
  state_t s_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic class_hit(input lim_class_t cls, input logic bc,
                                     input logic mc, input logic fld);
    case (cls)
      CLS_ALL:     class_hit = 1'b1;
      CLS_BMC_FLD: class_hit = bc | mc | fld;
      CLS_BMC:     class_hit = bc | mc;
      default:     class_hit = bc;
    endcase
  endfunction : class_hit

  // Code zero is treated as unlimited, so an unconfigured limiter never drops traffic.
  function automatic logic [23:0] budget(input logic [6:0] code, input logic pps);
    logic [23:0] unit;
    unit   = pps ? `PKTS_PER_CODE : `BITS_PER_CODE;
    budget = 24'(code) * unit;
  endfunction : budget

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic        bad;
  logic        fc_drop;
  logic        win_end;
  logic        port_based;
  logic        pps;
  logic        lim_fc_en;
  logic [2:0]  idx;
  logic [23:0] bytes;
  logic [23:0] amount;
  logic [23:0] base;
  logic [23:0] used;
  logic        counted;
  logic        over;
  logic        storm_over;
  logic        fc_active;

  always_comb begin
    s_nxt      = s_r;
    port_based = s_r.rate_ctrl[`BIT_PORT_BASED];
    pps        = s_r.rate_ctrl[`BIT_PPS_MODE];
    lim_fc_en  = s_r.rate_ctrl[`BIT_LIM_FC_EN];
    bad        = frm_crc_err | frm_too_long | frm_too_short;
    fc_drop    = frm_is_fc & fc_filter_en;
    win_end    = (s_r.win_cnt == WIN_LAST);
    idx        = port_based ? 3'd0 : frm_prio;
    bytes      = 24'(frm_len);
    if (s_r.rate_ctrl[`BIT_CNT_IFG]) begin
      bytes = bytes + `IFG_BYTES;
    end
    if (s_r.rate_ctrl[`BIT_CNT_PRE] && !pps) begin
      bytes = bytes + `PRE_BYTES;
    end
    amount     = pps ? 24'd1 : 24'(bytes << 3);
    counted    = class_hit(lim_class_t'(s_r.rate_ctrl[3:2]),
                           frm_bcast, frm_mcast, frm_flood);
    base       = win_end ? 24'd0 : s_r.usage[idx];
    used       = base + amount;
    over       = counted && (s_r.act[idx] != 7'd0) &&
                 (used > budget(s_r.act[idx], pps));
    storm_over = s_r.storm_en && frm_bcast &&
                 ((win_end ? 24'd0 : s_r.bc_cnt) >= `STORM_LIMIT);
    fc_active  = lim_fc_en && port_fc_en;

    // Window bookkeeping; a frame landing on the boundary opens the new window.
    s_nxt.win_cnt = win_end ? 15'd0 : s_r.win_cnt + 15'd1;
    if (win_end) begin
      s_nxt.usage  = '0;
      s_nxt.hit    = '0;
      s_nxt.bc_cnt = '0;
    end

    // Register port.
    s_nxt.rdata = 8'h00;
    if (reg_wr) begin
      if (reg_addr == `OFS_MAC_STORM) begin
        s_nxt.storm_en = reg_wdata[`BIT_STORM_EN];
      end else if (reg_addr == `OFS_MAC_BACKPR) begin
        s_nxt.backpr_en = reg_wdata[`BIT_BACKPR_EN];
        s_nxt.pass_all  = reg_wdata[`BIT_PASS_ALL];
      end else if (reg_addr == `OFS_RATE_CTRL) begin
        s_nxt.rate_ctrl = reg_wdata[6:0];
      end else if (reg_addr >= `OFS_PRIO_LIM_BASE && reg_addr <= `OFS_PRIO_LIM_LAST) begin
        s_nxt.pend[reg_addr[2:0]] = reg_wdata[6:0];
        if (reg_addr == `OFS_PRIO_LIM_LAST) begin
          s_nxt.act    = s_r.pend;
          s_nxt.act[7] = reg_wdata[6:0];
        end
      end
    end else if (reg_rd) begin
      if (reg_addr == `OFS_MAC_STORM) begin
        s_nxt.rdata = {6'h00, s_r.storm_en, 1'b0};
      end else if (reg_addr == `OFS_MAC_BACKPR) begin
        s_nxt.rdata = {4'h0, s_r.backpr_en, 2'b00, s_r.pass_all};
      end else if (reg_addr == `OFS_RATE_CTRL) begin
        s_nxt.rdata = {1'b0, s_r.rate_ctrl};
      end else if (reg_addr >= `OFS_PRIO_LIM_BASE && reg_addr <= `OFS_PRIO_LIM_LAST) begin
        s_nxt.rdata = {1'b0, s_r.pend[reg_addr[2:0]]};
      end else if (reg_addr == `OFS_LIM_STATUS) begin
        s_nxt.rdata = s_r.hit;
      end
    end

    // Frame decision, one cycle after the summary pulse.
    s_nxt.dec_valid       = frm_valid;
    s_nxt.dec_forward     = 1'b0;
    s_nxt.dec_mirror_only = 1'b0;
    s_nxt.dec_drop        = 1'b0;
    if (frm_valid) begin
      if (fc_drop) begin
        s_nxt.dec_drop = 1'b1;
      end else if (bad) begin
        s_nxt.dec_mirror_only = s_r.pass_all;
        s_nxt.dec_drop        = !s_r.pass_all;
      end else if (storm_over) begin
        s_nxt.dec_drop = 1'b1;
      end else if (over && !fc_active) begin
        s_nxt.dec_drop = 1'b1;
        s_nxt.hit[idx] = 1'b1;
      end else begin
        s_nxt.dec_forward = 1'b1;
        if (over) begin
          s_nxt.hit[idx] = 1'b1;
        end
        if (counted) begin
          s_nxt.usage[idx] = used;
        end
        if (frm_bcast) begin
          s_nxt.bc_cnt = (win_end ? 24'd0 : s_r.bc_cnt) + 24'd1;
        end
      end
    end

    // Flow control follows the hit flags of the current window.
    s_nxt.pause_req  = fc_active && full_duplex && (s_nxt.hit != 8'h00);
    s_nxt.backpr_req = fc_active && !full_duplex && s_r.backpr_en &&
                       (s_nxt.hit != 8'h00);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata        = s_r.rdata;
  assign dec_valid        = s_r.dec_valid;
  assign dec_forward      = s_r.dec_forward;
  assign dec_mirror_only  = s_r.dec_mirror_only;
  assign dec_drop         = s_r.dec_drop;
  assign pause_req        = s_r.pause_req;
  assign backpressure_req = s_r.backpr_req;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence bad_frame_s;
    ce && frm_valid && !fc_drop && (frm_crc_err || frm_too_long || frm_too_short);
  endsequence

  sequence commit_write_s;
    ce && reg_wr && (reg_addr == `OFS_PRIO_LIM_LAST);
  endsequence

  a_bad_drop: assert property (@(posedge core_clk) disable iff (!rstn)
    bad_frame_s and (!s_r.pass_all) |=> dec_drop && !dec_forward && !dec_mirror_only)
    else $error("bad frame not dropped");

  a_bad_mirror: assert property (@(posedge core_clk) disable iff (!rstn)
    bad_frame_s and s_r.pass_all |=> dec_mirror_only && !dec_forward && !dec_drop)
    else $error("bad frame not sent to mirroring only");

  a_fc_filter: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && frm_valid && frm_is_fc && fc_filter_en |=> dec_drop && !dec_mirror_only)
    else $error("flow control frame filtering changed");

  a_bp_half_only: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && full_duplex |=> !backpressure_req)
    else $error("back pressure in full duplex");

  a_fc_gate: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && (!port_fc_en || !s_r.rate_ctrl[`BIT_LIM_FC_EN]) |=> !pause_req && !backpressure_req)
    else $error("flow control without enables");

  a_pend_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && reg_wr && (reg_addr == `OFS_PRIO_LIM_BASE) |=> $stable(s_r.act))
    else $error("limit took effect before commit");

  a_commit_all: assert property (@(posedge core_clk) disable iff (!rstn)
    commit_write_s |=> (s_r.act[7] == $past(reg_wdata[6:0])) &&
                       (s_r.act[0] == $past(s_r.pend[0])))
    else $error("commit did not load limits");

  a_storm_off: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && frm_valid && !s_r.storm_en && frm_bcast && !bad && !fc_drop &&
    (s_r.act == '0) |=> dec_forward)
    else $error("broadcast dropped with storm protection off");

  a_class_skip: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && frm_valid && !bad && !fc_drop && !storm_over && !frm_bcast &&
    (s_r.rate_ctrl[3:2] == 2'b11) |=> dec_forward)
    else $error("uncounted frame class was limited");

  a_one_decision: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && frm_valid |=> dec_valid && $onehot({dec_drop, dec_mirror_only, dec_forward}))
    else $error("frame without exactly one decision");

  a_storm_drop: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && frm_valid && storm_over && !bad && !fc_drop |=> dec_drop)
    else $error("broadcast over storm limit forwarded");

  a_over_drop: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && frm_valid && over && !fc_active && !bad && !fc_drop && !storm_over |=> dec_drop)
    else $error("frame over limit forwarded without flow control");

  a_over_fc_fwd: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && frm_valid && over && fc_active && !bad && !fc_drop && !storm_over |=>
    dec_forward && s_r.hit != 8'h00)
    else $error("frame over limit not forwarded under flow control");

  a_read_ctrl: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && reg_rd && !reg_wr && (reg_addr == `OFS_RATE_CTRL) |=>
    reg_rdata == {1'b0, $past(s_r.rate_ctrl)})
    else $error("rate control readback wrong");

endmodule : port_ingress_mac_policy

// *** test/link_partner.sv ***
// Link partner model: hands the block one received-frame summary per call.
// Assumes the caller steps it from the block's own rising clock edge.
module link_partner (
  input  wire logic        core_clk,
  output logic             frm_valid,
  output logic [13:0]      frm_len,
  output logic [2:0]       frm_prio,
  output logic             frm_crc_err,
  output logic             frm_too_long,
  output logic             frm_too_short,
  output logic             frm_is_fc,
  output logic             frm_bcast,
  output logic             frm_mcast,
  output logic             frm_flood
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    frm_valid = 1'b0;
    {frm_len, frm_prio, frm_crc_err, frm_too_long, frm_too_short} = '0;
    {frm_is_fc, frm_bcast, frm_mcast, frm_flood} = 4'h0;
  end

  task automatic send(input logic [13:0] len, input logic [2:0] prio,
                      input logic [3:0] bad, input logic [2:0] cls);
    @(posedge core_clk);
    frm_valid <= 1'b1;
    frm_len <= len;
    frm_prio <= prio;
    {frm_crc_err, frm_too_long, frm_too_short, frm_is_fc} <= bad;
    {frm_bcast, frm_mcast, frm_flood} <= cls;
  endtask : send

  // Summary lines are inverted between frames, so a block that reads them without
  // the valid pulse sees wrong values rather than the last frame's.
  task automatic idle();
    @(posedge core_clk);
    frm_valid <= 1'b0;
    {frm_len, frm_prio, frm_crc_err, frm_too_long, frm_too_short, frm_is_fc, frm_bcast,
     frm_mcast, frm_flood} <= ~{frm_len, frm_prio, frm_crc_err, frm_too_long,
     frm_too_short, frm_is_fc, frm_bcast, frm_mcast, frm_flood};
  endtask : idle
endmodule : link_partner

// *** test/tb_top.sv ***
// Self-checking bench for the ingress MAC policy block with a 128-cycle limiter window.
// Assumes the window counter starts at zero with the first edge after reset release.
`include "port_ingress_mac_policy_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Decisions are one-hot {drop, mirror, forward}; dec holds three frames, first on top.
  typedef struct packed {
    logic [7:0] c401;
    logic [7:0] c403;
    logic [2:0] lnk;
    logic [3:0] bad;
    logic [2:0] cls;
    logic [2:0] prio;
    logic [8:0] dec;
    logic [1:0] fc;
  } row_t;
  localparam int unsigned WIN = 128;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        full_duplex = 1'b1;
  logic        port_fc_en = 1'b0;
  logic        fc_filter_en = 1'b1;
  logic        frm_valid, frm_crc_err, frm_too_long, frm_too_short, frm_is_fc;
  logic        frm_bcast, frm_mcast, frm_flood;
  logic [13:0] frm_len;
  logic [2:0]  frm_prio;
  logic        dec_valid, dec_forward, dec_mirror_only, dec_drop, pause_req, backpressure_req;
  logic [2:0]  dq[$];
  int unsigned cyc = 0;
  int unsigned tick = 0;
  int          fails = 0;
  int          samples_checked = 0;
  row_t        rows [22] = '{
    '{8'h00, 8'h00, 3'h5, 4'h0, 3'h0, 3'h1, 9'h049, 2'h0},
    '{8'h00, 8'h00, 3'h5, 4'h8, 3'h0, 3'h1, 9'h124, 2'h0},
    '{8'h00, 8'h00, 3'h5, 4'h4, 3'h0, 3'h1, 9'h124, 2'h0},
    '{8'h00, 8'h00, 3'h5, 4'h2, 3'h0, 3'h1, 9'h124, 2'h0},
    '{8'h01, 8'h00, 3'h5, 4'h8, 3'h0, 3'h1, 9'h092, 2'h0},
    '{8'h01, 8'h00, 3'h5, 4'h1, 3'h0, 3'h1, 9'h124, 2'h0},
    '{8'h01, 8'h00, 3'h4, 4'h1, 3'h0, 3'h1, 9'h049, 2'h0},
    '{8'h00, 8'h20, 3'h7, 4'h0, 3'h0, 3'h0, 9'h04C, 2'h0},
    '{8'h00, 8'h00, 3'h5, 4'h0, 3'h0, 3'h0, 9'h04C, 2'h0},
    '{8'h00, 8'h02, 3'h5, 4'h0, 3'h0, 3'h0, 9'h064, 2'h0},
    '{8'h00, 8'h01, 3'h5, 4'h0, 3'h0, 3'h0, 9'h064, 2'h0},
    '{8'h00, 8'h21, 3'h5, 4'h0, 3'h0, 3'h0, 9'h04C, 2'h0},
    '{8'h00, 8'h40, 3'h5, 4'h0, 3'h0, 3'h1, 9'h04C, 2'h0},
    '{8'h00, 8'h2C, 3'h5, 4'h0, 3'h2, 3'h0, 9'h049, 2'h0},
    '{8'h00, 8'h2C, 3'h5, 4'h0, 3'h4, 3'h0, 9'h04C, 2'h0},
    '{8'h00, 8'h24, 3'h5, 4'h0, 3'h1, 3'h0, 9'h04C, 2'h0},
    '{8'h00, 8'h28, 3'h5, 4'h0, 3'h1, 3'h0, 9'h049, 2'h0},
    '{8'h00, 8'h28, 3'h5, 4'h0, 3'h2, 3'h0, 9'h04C, 2'h0},
    '{8'h08, 8'h30, 3'h7, 4'h0, 3'h0, 3'h0, 9'h049, 2'h2},
    '{8'h00, 8'h30, 3'h5, 4'h0, 3'h0, 3'h0, 9'h04C, 2'h0},
    '{8'h08, 8'h30, 3'h3, 4'h0, 3'h0, 3'h0, 9'h049, 2'h1},
    '{8'h00, 8'h2C, 3'h5, 4'h0, 3'h4, 3'h1, 9'h049, 2'h0}
  };

  port_ingress_mac_policy #(.WINDOW_CYCLES(WIN)) DUT (
    .core_clk, .rstn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .full_duplex, .port_fc_en, .fc_filter_en, .frm_valid, .frm_len, .frm_prio,
    .frm_crc_err, .frm_too_long, .frm_too_short, .frm_bcast, .frm_mcast, .frm_flood,
    .frm_is_fc, .dec_valid, .dec_forward, .dec_mirror_only, .dec_drop, .pause_req,
    .backpressure_req);
  link_partner lp (.core_clk, .frm_valid, .frm_len, .frm_prio, .frm_crc_err, .frm_too_long,
    .frm_too_short, .frm_is_fc, .frm_bcast, .frm_mcast, .frm_flood);

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) cyc <= 0;
    else cyc <= cyc + 1;
  end
  always @(posedge core_clk) begin
    if (dec_valid === 1'b1) dq.push_back({dec_drop, dec_mirror_only, dec_forward});
    tick <= tick + 1;
    if (tick == 12000) begin
      fails++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Bus, traffic and check tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("counts: checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check({1'b0, reg_rdata}, {1'b0, e});
  endtask : rdchk
  // Bursts start at cycle 20 of the window so a limiter budget is never split across two windows.
  task automatic burst(input int n, input logic [2:0] prio, input logic [3:0] bad,
                       input logic [2:0] cls);
    do @(negedge core_clk); while (cyc % WIN != 20);
    dq.delete();
    repeat (n) lp.send(14'h003C, prio, bad, cls);
    lp.idle();
    repeat (3) @(negedge core_clk);
  endtask : burst
  task automatic storm(input logic [8:0] exp);
    logic [8:0] nf;
    nf = 9'h000;
    burst(70, 3'h1, 4'h0, 3'h4);
    foreach (dq[i]) nf = nf + 9'(dq[i][0]);
    check(nf, exp);
  endtask : storm

  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    wr(`OFS_PRIO_LIM_BASE, 8'h01);
    wr(`OFS_PRIO_LIM_LAST, 8'h00);
    foreach (rows[i]) begin
      wr(`OFS_MAC_BACKPR, rows[i].c401);
      wr(`OFS_RATE_CTRL, rows[i].c403);
      {full_duplex, port_fc_en, fc_filter_en} <= rows[i].lnk;
      burst(3, rows[i].prio, rows[i].bad, rows[i].cls);
      check({dq[0], dq[1], dq[2]}, rows[i].dec);
      check({7'h00, pause_req, backpressure_req}, 9'(rows[i].fc));
    end
    wr(`OFS_MAC_STORM, 8'h02);
    storm(9'h040);
    wr(`OFS_MAC_STORM, 8'h00);
    storm(9'h046);
    wr(`OFS_RATE_CTRL, 8'h20);
    wr(`OFS_PRIO_LIM_BASE, 8'h00);
    burst(3, 3'h0, 4'h0, 3'h0);
    check({dq[0], dq[1], dq[2]}, 9'h04C);
    rdchk(`OFS_LIM_STATUS, 8'h01);
    wr(`OFS_PRIO_LIM_LAST, 8'h00);
    burst(3, 3'h0, 4'h0, 3'h0);
    check({dq[0], dq[1], dq[2]}, 9'h049);
    wr(`OFS_RATE_CTRL, 8'hFF);
    rdchk(`OFS_RATE_CTRL, 8'h7F);
    wr(`OFS_MAC_BACKPR, 8'hFF);
    rdchk(`OFS_MAC_BACKPR, 8'h09);
    wr(`OFS_MAC_STORM, 8'hFF);
    rdchk(`OFS_MAC_STORM, 8'h02);
    wr(`OFS_PRIO_LIM_BASE, 8'h55);
    rdchk(`OFS_PRIO_LIM_BASE, 8'h55);
    rdchk(12'h0FF, 8'h00);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(negedge core_clk);
    check({6'h00, dec_valid, pause_req, backpressure_req}, 9'h000);
    @(posedge core_clk);
    rstn <= 1'b1;
    rdchk(`OFS_MAC_STORM, 8'h00);
    rdchk(`OFS_MAC_BACKPR, 8'h00);
    rdchk(`OFS_RATE_CTRL, 8'h00);
    stop_test();
  end
endmodule : tb_top
